/* pkg/pcb_pkg.sv */
// constants for the control-bus slave port of the phy controller
package pcb_pkg;
   // ***************
   // bus geometry
   // ***************
   localparam int unsigned NUM_REGS = 32; // register count
   localparam int unsigned ADDR_W = 5; // address width
   localparam int unsigned DATA_W = 8; // data width
   // ***************
   // register map (offsets chosen here)
   // ***************
   localparam logic [4:0] ADDR_MODE = 5'h00; // mode register, bit 0 run
   localparam logic [4:0] ADDR_IRQ_COND = 5'h01; // interrupt condition, write one to clear
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h02; // interrupt mask, one enables
   localparam int unsigned BIT_PARITY_ERR = 0; // parity error flag position
   localparam int unsigned BIT_RUN_MODE = 0; // run mode bit position
   localparam logic [7:0] REG_RESET = 8'h00; // every register clears on reset
   // ***************
   // timing
   // ***************
   localparam int unsigned CLK_MHZ = 100; // local byte clock rate in this model
   localparam int unsigned RST_MIN_NS = 160; // least reset pulse width
   localparam int unsigned RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000; // rounded up
   // cycle states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, // waiting for chip select
      ST_ACK = 3'b010, // acknowledge held
      ST_DONE = 3'b100 // unused spare code guard
   } pcb_state_t;
endpackage

/* rtl/pcb_port.sv */
// control-bus slave port with 32 byte registers, parity and interrupt
`timescale 1ns/1ps
module pcb_port (
   input wire logic clk, // local byte clock
   input wire logic rst_n, // async reset, active low
   input wire logic chip_en_n, // chip select from host, async
   input wire logic read_not_write, // high read, low write
   input wire logic [4:0] reg_addr, // register address
   input wire logic [7:0] reg_data_in, // data pin input
   output logic [7:0] reg_data_out, // data pin drive value
   output logic reg_data_oe_n, // data pin enable, low drives
   input wire logic reg_data_parity_in, // parity pin input
   output logic reg_data_parity_out, // parity pin drive value
   output logic reg_data_parity_oe_n, // parity pin enable, low drives
   input wire logic parity_check_en, // write parity check enable
   output logic ack_out, // acknowledge pin value, always low
   output logic ack_oe_n, // acknowledge open drain, low pulls
   output logic irq_out, // interrupt pin value, always low
   output logic irq_oe_n, // interrupt open drain, low pulls
   input wire logic [7:0] irq_event, // hardware condition pulses
   output logic run_mode // mode bit, low is stop mode
);
   // ***************
   // input synchronisers
   // ***************
   logic [1:0] ce_sync; // chip select pipe, stage 0 read only by stage 1
   logic pce_q1; // parity enable stage one
   logic pce_q; // parity enable synchronised
   logic rw_q1; // direction, first stage
   logic rw_q; // sampled direction
   logic [4:0] addr_q1; // address, first stage
   logic [4:0] addr_q; // sampled address
   logic [7:0] wdata_q1; // write data, first stage
   logic [7:0] wdata_q; // sampled write data
   logic wpar_q1; // write parity, first stage
   logic wpar_q; // sampled write parity

   // select and parity enable: two flops each; the reset value of the
   // select pipe is the pin's idle level, so release makes no false start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ce_sync <= 2'b11; // idle, no cycle
         pce_q1 <= 1'b0;
         pce_q <= 1'b0;
      end else begin
         ce_sync <= {ce_sync[0], chip_en_n};
         pce_q1 <= parity_check_en;
         pce_q <= pce_q1;
      end
   end

   // bus qualifiers: two flops as well, so they reach the decode with the
   // same lag as the select; the host holds them from select low, so the
   // second stage is settled when the synchronised select first shows
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rw_q1 <= 1'b1; // read direction, harmless at idle
         rw_q <= 1'b1;
         addr_q1 <= 5'h00;
         addr_q <= 5'h00;
         wdata_q1 <= 8'h00;
         wdata_q <= 8'h00;
         wpar_q1 <= 1'b0;
         wpar_q <= 1'b0;
      end else begin
         rw_q1 <= read_not_write; // first stage only feeds the second
         rw_q <= rw_q1;
         addr_q1 <= reg_addr;
         addr_q <= addr_q1;
         wdata_q1 <= reg_data_in;
         wdata_q <= wdata_q1;
         wpar_q1 <= reg_data_parity_in;
         wpar_q <= wpar_q1;
      end
   end

   // the select and its qualifiers share one lag, so a cycle is decoded
   // from values that all belong to it
   wire ce_active = ~ce_sync[1]; // synchronised select, high in cycle
   pcb_pkg::pcb_state_t state; // cycle state
   pcb_pkg::pcb_state_t next_state; // next cycle state
   wire start = (state == pcb_pkg::ST_IDLE) && ce_active;
   wire do_write = start && !rw_q; // write taken this edge
   wire do_read = start && rw_q; // read taken this edge
   // nine bits with an odd count of ones xor to one
   wire par_ok = ^{wdata_q, wpar_q};
   // the check applies to writes only; reads always carry parity
   wire write_ok = do_write && (par_ok || !pce_q);
   wire par_fail = do_write && !par_ok && pce_q;

   // ***************
   // handshake state machine
   // ***************
   // idle until the synchronised select shows, then hold the acknowledge
   // for as long as the select stays low; no timeout, the host ends it
   always_comb begin
      next_state = state; // stay by default
      unique case (state)
         pcb_pkg::ST_IDLE: begin
            if (ce_active) next_state = pcb_pkg::ST_ACK;
         end
         pcb_pkg::ST_ACK: begin
            if (!ce_active) next_state = pcb_pkg::ST_IDLE;
         end
         default: next_state = pcb_pkg::ST_IDLE; // illegal codes recover
      endcase
   end

   // state register; reset lands in idle with the acknowledge released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) state <= pcb_pkg::ST_IDLE;
      else state <= next_state;
   end

   // ***************
   // register file
   // ***************
   // the array depth comes from the package so the map stays in one place
   localparam int unsigned NUM_REGS_L = pcb_pkg::NUM_REGS; // local copy
   logic [7:0] regs [NUM_REGS_L]; // register array
   // hardware events and a refused write both raise condition bits
   wire [7:0] cond_set = irq_event | (par_fail ? (8'h01 << pcb_pkg::BIT_PARITY_ERR) : 8'h00); // new events
   // write one to clear, taken only from a write that passed its check
   wire cond_wr = write_ok && (addr_q == pcb_pkg::ADDR_IRQ_COND); // clear strobe

   // one process per entry; condition register sets win over clears,
   // so an event that lands with a clearing write is never lost; plain
   // entries simply take any write that passed its parity check
   genvar gi;
   generate
      for (gi = 0; gi < pcb_pkg::NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) regs[gi] <= pcb_pkg::REG_RESET;
            else if (gi == int'(pcb_pkg::ADDR_IRQ_COND))
               regs[gi] <= (regs[gi] & ~(cond_wr ? wdata_q : 8'h00)) | cond_set;
            else if (write_ok && addr_q == 5'(gi)) regs[gi] <= wdata_q;
         end
      end
   endgenerate

   // ***************
   // read data and drive
   // ***************
   logic [7:0] rdata; // captured read byte
   logic rpar; // captured read parity bit
   logic rd_drive; // data pins driven
   wire [7:0] rd_sel = regs[addr_q]; // byte chosen by the sampled address
   wire rd_par = ~(^rd_sel); // odd parity over the chosen byte
   wire rd_cont = (state == pcb_pkg::ST_IDLE) ? rw_q : rd_drive; // new read, or keep

   // byte and parity are caught once as the cycle starts and then stand
   // untouched for the whole acknowledge, whatever the pins do meanwhile
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
         rpar <= 1'b1; // odd parity of the zero byte
         rd_drive <= 1'b0;
      end else begin
         if (do_read) begin
            rdata <= rd_sel;
            rpar <= rd_par;
         end
         rd_drive <= (next_state == pcb_pkg::ST_ACK) && rd_cont;
      end
   end

   // read pins: byte and parity from flops, enabled only for a read
   assign reg_data_out = rdata;
   assign reg_data_oe_n = ~rd_drive;
   assign reg_data_parity_out = rpar;
   assign reg_data_parity_oe_n = ~rd_drive;
   // open-drain pins: the value is fixed low, the enable does the work
   assign ack_out = 1'b0;
   assign ack_oe_n = ~(state == pcb_pkg::ST_ACK);
   // the interrupt is a level: any pending condition whose mask bit is set
   wire irq_pend = |(regs[pcb_pkg::ADDR_IRQ_COND] & regs[pcb_pkg::ADDR_IRQ_MASK]);
   assign irq_out = 1'b0;
   assign irq_oe_n = ~irq_pend;
   // a cleared mode bit is stop mode, so reset leaves the device stopped
   assign run_mode = regs[pcb_pkg::ADDR_MODE][pcb_pkg::BIT_RUN_MODE];

   // ***************
   // assertions
   // ***************
   // handshake: acknowledge follows the synchronised select
   chk_ack_holds: assert property (@(posedge clk) disable iff (!rst_n)
      (!ack_oe_n && ce_active) |=> !ack_oe_n) else $error("ack released while select low");
   chk_ack_after_ce: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(ack_oe_n) |-> $past(ce_sync[1] == 1'b0)) else $error("ack without synced select");
   chk_ack_timely: assert property (@(posedge clk) disable iff (!rst_n)
      (state == pcb_pkg::ST_IDLE && ce_active) |=> !ack_oe_n) else $error("ack late");
   chk_ack_release: assert property (@(posedge clk) disable iff (!rst_n)
      (!ack_oe_n && !ce_active) |=> ack_oe_n) else $error("ack not released after select");
   // read drive: data stands, writes leave the pins alone; then parity flag, mask and write checks
   chk_write_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      ($fell(ack_oe_n) && !$past(rw_q)) |-> reg_data_oe_n) else $error("data driven on a write");
   chk_read_drive: assert property (@(posedge clk) disable iff (!rst_n)
      (!ack_oe_n && rd_drive) |-> !reg_data_oe_n && $stable(reg_data_out) || $rose(rd_drive))
      else $error("read data moved under ack");
   chk_read_parity: assert property (@(posedge clk) disable iff (!rst_n)
      !reg_data_parity_oe_n |-> (^{reg_data_out, reg_data_parity_out}) == 1'b1) else $error("read parity not odd");
   chk_bad_write: assert property (@(posedge clk) disable iff (!rst_n)
      par_fail |=> regs[pcb_pkg::ADDR_IRQ_COND][pcb_pkg::BIT_PARITY_ERR]) else $error("parity flag not set");
   chk_no_write: assert property (@(posedge clk) disable iff (!rst_n)
      (par_fail && addr_q == pcb_pkg::ADDR_MODE) |=> $stable(run_mode)) else $error("bad write landed");
   chk_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
      (regs[pcb_pkg::ADDR_IRQ_MASK] == 8'h00) |-> irq_oe_n) else $error("masked interrupt asserted");
   chk_write_data: assert property (@(posedge clk) disable iff (!rst_n)
      (do_write && !pce_q && addr_q == pcb_pkg::ADDR_IRQ_MASK) |=> regs[pcb_pkg::ADDR_IRQ_MASK] == $past(wdata_q))
      else $error("unchecked write lost");
   // register and interrupt behaviour
   chk_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
      (write_ok && addr_q == pcb_pkg::ADDR_MODE) |=> run_mode == $past(wdata_q[pcb_pkg::BIT_RUN_MODE]))
      else $error("mode write lost");
   chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (regs[pcb_pkg::ADDR_IRQ_COND][pcb_pkg::BIT_PARITY_ERR] && !cond_wr)
      |=> regs[pcb_pkg::ADDR_IRQ_COND][pcb_pkg::BIT_PARITY_ERR]) else $error("parity flag lost");
   // no disable here: this one has to see the edge right after release
   chk_reset_stop: assert property (@(posedge clk)
      $rose(rst_n) |-> !run_mode) else $error("not in stop mode after reset");
   // coverage of the main scenarios
   cov_read: cover property (@(posedge clk) disable iff (!rst_n) do_read ##1 !ack_oe_n ##[1:20] ack_oe_n);
   cov_write: cover property (@(posedge clk) disable iff (!rst_n) write_ok);
   cov_par_err: cover property (@(posedge clk) disable iff (!rst_n) par_fail);
   cov_irq: cover property (@(posedge clk) disable iff (!rst_n) !irq_oe_n);
   cov_hold: cover property (@(posedge clk) disable iff (!rst_n) (!ack_oe_n) [*3]);
endmodule // pcb_port

/* dv/pcb_host.sv */
// processor model that runs control-bus cycles against the port
`timescale 1ns/1ps
module pcb_host (
   input wire logic clk, // byte clock
   output logic chip_en_n, // chip select
   output logic read_not_write, // direction
   output logic [4:0] reg_addr, // address
   output logic [7:0] reg_data_in, // resolved data pins
   output logic reg_data_parity_in, // resolved parity pin
   input wire logic [7:0] reg_data_out, // device data
   input wire logic reg_data_oe_n, // device data enable
   input wire logic reg_data_parity_out, // device parity
   input wire logic reg_data_parity_oe_n, // device parity enable
   input wire logic ack_oe_n // acknowledge pull
);
   logic [7:0] drv_d = 8'h00; // host data
   logic drv_p = 1'b1; // host parity
   logic drv_on = 1'b0; // host drives the pins
   logic last_ack = 1'b1; // ack seen at end of hold
   // no pulls on data: a released line shows the inverse of the last value
   assign reg_data_in = !reg_data_oe_n ? reg_data_out : drv_on ? drv_d : ~drv_d;
   assign reg_data_parity_in = !reg_data_parity_oe_n ? reg_data_parity_out : drv_on ? drv_p : ~drv_p;
   initial begin
      chip_en_n = 1'b1;
      read_not_write = 1'b1;
      reg_addr = 5'h00;
   end
   // one cycle; slow stretches the hold after ack
   task automatic cyc(input logic rw, input logic [4:0] a, input logic [7:0] d, input logic p,
                      input int slow, output logic [7:0] q, output logic qp);
      int n;
      n = 0;
      @(negedge clk);
      read_not_write = rw;
      reg_addr = a;
      drv_d = d;
      drv_p = p;
      drv_on = ~rw;
      @(negedge clk);
      chip_en_n = 1'b0;
      while (ack_oe_n !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      repeat (slow) @(negedge clk);
      q = (n < 20) ? reg_data_in : 8'hxx;
      qp = reg_data_parity_in;
      last_ack = ack_oe_n;
      chip_en_n = 1'b1;
      drv_on = 1'b0;
      // select stays high well past the spacing the port needs
      repeat (4) @(negedge clk);
   endtask
endmodule // pcb_host

/* dv/tb_pcb_port.sv */
// self-checking bench for the control-bus slave port
`timescale 1ns/1ps
module tb_pcb_port;
   logic clk = 1'b0; // byte clock
   logic rst_n = 1'b0; // reset
   logic parity_check_en = 1'b0; // write parity check
   logic [7:0] irq_event = 8'h00; // condition pulses
   logic chip_en_n, read_not_write, reg_data_parity_in, reg_data_parity_out, reg_data_parity_oe_n;
   logic reg_data_oe_n, ack_oe_n, irq_oe_n, run_mode, qp;
   logic [4:0] reg_addr; // address
   logic [7:0] reg_data_in, reg_data_out, q;
   int miscompares = 0; // mismatch count
   int n_tests = 0; // comparison count
   initial begin
      forever #5 clk = ~clk;
   end
   pcb_port u_pcb_port (.clk(clk), .rst_n(rst_n), .chip_en_n(chip_en_n), .read_not_write(read_not_write),
      .reg_addr(reg_addr), .reg_data_in(reg_data_in), .reg_data_out(reg_data_out), .reg_data_oe_n(reg_data_oe_n),
      .reg_data_parity_in(reg_data_parity_in), .reg_data_parity_out(reg_data_parity_out),
      .reg_data_parity_oe_n(reg_data_parity_oe_n), .parity_check_en(parity_check_en), .ack_out(),
      .ack_oe_n(ack_oe_n), .irq_out(), .irq_oe_n(irq_oe_n), .irq_event(irq_event), .run_mode(run_mode));
   pcb_host u_pcb_host (.clk(clk), .chip_en_n(chip_en_n), .read_not_write(read_not_write), .reg_addr(reg_addr),
      .reg_data_in(reg_data_in), .reg_data_parity_in(reg_data_parity_in), .reg_data_out(reg_data_out),
      .reg_data_oe_n(reg_data_oe_n), .reg_data_parity_out(reg_data_parity_out),
      .reg_data_parity_oe_n(reg_data_parity_oe_n), .ack_oe_n(ack_oe_n));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input int slow);
      u_pcb_host.cyc(1'b1, a, 8'h00, 1'b0, slow, q, qp);
      chk(q, exp);
      chk({7'h0, qp}, {7'h0, ~^exp});
   endtask
   // bad flips the parity bit away from odd
   task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic bad);
      u_pcb_host.cyc(1'b0, a, d, ~^d ^ bad, 0, q, qp);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      chk({7'h0, run_mode}, 8'h00);
      for (int a = 0; a < 32; a++) rd(a[4:0], 8'h00, 0);
      $display("reset test done");
      for (int a = 3; a < 32; a++) wr(a[4:0], a[7:0] ^ 8'ha5, 1'b0);
      for (int a = 3; a < 32; a++) rd(a[4:0], a[7:0] ^ 8'ha5, a % 3);
      chk({7'h0, u_pcb_host.last_ack}, 8'h00);
      chk({7'h0, ack_oe_n}, 8'h01);
      wr(5'h00, 8'h01, 1'b0);
      chk({7'h0, run_mode}, 8'h01);
      $display("storage test done");
      wr(5'h07, 8'h3c, 1'b1);
      rd(5'h07, 8'h3c, 0);
      wr(5'h02, 8'h40, 1'b1);
      rd(5'h02, 8'h40, 0);
      parity_check_en = 1'b1;
      wr(5'h07, 8'hc3, 1'b1);
      rd(5'h07, 8'h3c, 0);
      wr(5'h00, 8'h00, 1'b1);
      chk({7'h0, run_mode}, 8'h01);
      rd(5'h01, 8'h01, 0);
      chk({7'h0, irq_oe_n}, 8'h01);
      wr(5'h02, 8'h01, 1'b0);
      chk({7'h0, irq_oe_n}, 8'h00);
      wr(5'h01, 8'h01, 1'b0);
      chk({7'h0, irq_oe_n}, 8'h01);
      $display("parity test done");
      irq_event = 8'h08;
      @(negedge clk);
      irq_event = 8'h00;
      rd(5'h01, 8'h08, 0);
      chk({7'h0, irq_oe_n}, 8'h01);
      wr(5'h02, 8'h08, 1'b0);
      chk({7'h0, irq_oe_n}, 8'h00);
      $display("interrupt test done");
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      chk({7'h0, run_mode}, 8'h00);
      chk({7'h0, irq_oe_n}, 8'h01);
      rd(5'h02, 8'h00, 0);
      $display("second reset test done");
      wrap_up();
   end
   // the run needs about 980 cycles, so this leaves wide margin
   initial begin
      #200us;
      miscompares++;
      wrap_up();
   end
endmodule // tb_pcb_port
